// ---- adcc_analog_model.sv ----
// Analog front end model: sixteen inputs, sample-hold and comparator
`default_nettype none

module adcc_analog_model
  import adcc_pkg::*;
(
  // Clock
  input  wire logic       ref_clk_in,
  // Converter side
  input  wire logic [3:0] channel_select_in,
  input  wire logic       analog_input_gate_in,
  input  wire logic       sample_hold_in,
  input  wire logic [9:0] dac_code_in,
  // Comparator
  output logic            cmp_high_out
);
  logic [9:0] held = 10'h000;

  // Sample-hold captures the routed input; a gated input reads as ground
  always_ff @(posedge ref_clk_in) begin
    if (sample_hold_in) begin
      held <= analog_input_gate_in ? 10'h000 : 10'(channel_select_in * 61 + 17);
    end
  end

  // Input sits half a step above its code, so ties resolve upward
  assign cmp_high_out = (held >= dac_code_in);
endmodule

`default_nettype wire

// ---- adcc_control.sv ----
// Converter control: registers, sequencer and analog-side controls
//
// The strobed register port was chosen for this implementation.
`default_nettype none

module adcc_control
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Register bus
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // Power mode
  input  wire logic        low_power_in,
  // Analog side
  input  wire logic        cmp_high_in,
  output logic [3:0]       channel_select_out,
  output logic             analog_input_gate_out,
  output logic             ladder_connect_out,
  output logic             sample_hold_out,
  output logic [9:0]       dac_code_out,
  // Completion event
  output logic             conv_done_irq_out
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic        conv_trigger;
  logic [1:0]  conv_op_mode;
  logic        analog_input_gate;
  logic [3:0]  channel_select;
  logic [5:0]  timing_store;
  logic        conv_done_flag;
  logic [9:0]  result;
  logic        cmp_meta;
  logic        cmp_sync;
  adcc_state_e state;
  adcc_state_e next_state;

  // Timer and SAR links
  logic        step_pulse;
  logic        last_pulse;
  logic [3:0]  step_idx;
  logic [9:0]  sar_code;

  // ----------------------------------------
  // Address decode and field views
  // ----------------------------------------
  wire logic hit_ctrl_a = (reg_addr_in == ADCC_OFS_CTRL_A);
  wire logic hit_timing = (reg_addr_in == ADCC_OFS_TIMING);
  wire logic hit_status = (reg_addr_in == ADCC_OFS_STATUS);
  wire logic hit_upper  = (reg_addr_in == ADCC_OFS_UPPER);

  // Writes are blocked while a low-power mode holds the block
  wire logic wr_ctrl_a  = reg_wr_in && hit_ctrl_a && !low_power_in;
  wire logic wr_timing  = reg_wr_in && hit_timing && !low_power_in;
  wire logic rd_upper   = reg_rd_in && hit_upper;

  wire logic       ladder_connect = timing_store[ADCC_TC_LADDER_BIT];
  wire logic [2:0] time_code      = timing_store[ADCC_TC_TIME_HI:ADCC_TC_TIME_LO];
  wire logic [6:0] step_len       = adcc_step_len(time_code);

  // Single and repeat are the only modes that convert
  wire logic mode_single = (conv_op_mode == ADCC_MODE_SINGLE);
  wire logic mode_repeat = (conv_op_mode == ADCC_MODE_REPEAT);
  wire logic mode_active = mode_single || mode_repeat;

  // ----------------------------------------
  // Sequencer decode
  // ----------------------------------------
  wire logic conv_busy_flag = (state != ADCC_ST_IDLE);
  wire logic abort_conv     = low_power_in || !mode_active;
  wire logic start_first    = (state == ADCC_ST_IDLE) && conv_trigger && !abort_conv;
  wire logic store_now      = (state == ADCC_ST_STORE) && !abort_conv;
  wire logic start_repeat   = store_now && mode_repeat;
  wire logic start_conv     = start_first || start_repeat;
  wire logic timer_run      = (state == ADCC_ST_SAMPLE) || (state == ADCC_ST_CONVERT);
  wire logic sar_decide     = step_pulse && (state == ADCC_ST_CONVERT);
  wire logic [3:0] bit_pos  = ADCC_STEP_LAST - step_idx;

  // Done flag: a completion wins over a clear in the same cycle
  wire logic done_clear     = rd_upper || start_conv;
  wire logic next_done      = store_now || (conv_done_flag && !done_clear);

  // Outside low power the ladder joins while converting, or always when asked
  wire logic next_ladder    = !low_power_in && (ladder_connect || start_conv ||
                              (conv_busy_flag && !abort_conv));

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic [7:0] rd_ctrl_a = {conv_trigger, conv_op_mode, analog_input_gate, channel_select};
  wire logic [7:0] rd_timing = {2'h0, timing_store};
  wire logic [7:0] rd_status = {result[1:0], conv_done_flag, conv_busy_flag, 4'h0};
  wire logic [7:0] rd_upper_v = result[9:2];

  wire logic [7:0] next_rdata =
    !reg_rd_in ? ADCC_RD_IDLE :
    hit_ctrl_a ? rd_ctrl_a :
    hit_timing ? rd_timing :
    hit_status ? rd_status :
    hit_upper  ? rd_upper_v : ADCC_RD_IDLE;

  // ----------------------------------------
  // Comparator synchroniser
  // ----------------------------------------

  // Comparator comes from the analog domain
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_high_in;
      cmp_sync <= cmp_meta;
    end
  end

  // ----------------------------------------
  // Control register A
  // ----------------------------------------

  // Fields and trigger; low power returns everything to reset value
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {conv_trigger, conv_op_mode, analog_input_gate, channel_select} <= ADCC_CTRL_A_RST;
    end else if (low_power_in) begin
      {conv_trigger, conv_op_mode, analog_input_gate, channel_select} <= ADCC_CTRL_A_RST;
    end else if (wr_ctrl_a) begin
      conv_trigger      <= reg_wdata_in[ADCC_CA_TRIG_BIT];
      conv_op_mode      <= reg_wdata_in[ADCC_CA_MODE_HI:ADCC_CA_MODE_LO];
      analog_input_gate <= reg_wdata_in[ADCC_CA_GATE_BIT];
      channel_select    <= reg_wdata_in[ADCC_CA_CHAN_HI:0];
    end else if (start_first) begin
      conv_trigger      <= 1'b0;
    end
  end

  // ----------------------------------------
  // Timing control register
  // ----------------------------------------

  // Low six bits stored as written; top two are not kept
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timing_store <= ADCC_TIMING_RST;
    end else if (low_power_in) begin
      timing_store <= ADCC_TIMING_RST;
    end else if (wr_timing) begin
      timing_store <= reg_wdata_in[ADCC_TC_STORE_HI:0];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------

  // Next state: sample, convert ten bits, store, then stop or repeat
  always_comb begin
    next_state = state;
    unique case (state)
      ADCC_ST_IDLE: begin
        if (start_first) begin
          next_state = ADCC_ST_SAMPLE;
        end
      end
      ADCC_ST_SAMPLE: begin
        if (step_pulse && step_idx == ADCC_SAMPLE_LAST) begin
          next_state = ADCC_ST_CONVERT;
        end
      end
      ADCC_ST_CONVERT: begin
        if (last_pulse) begin
          next_state = ADCC_ST_STORE;
        end
      end
      ADCC_ST_STORE: begin
        next_state = mode_repeat ? ADCC_ST_SAMPLE : ADCC_ST_IDLE;
      end
    endcase
    if (abort_conv) begin
      next_state = ADCC_ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ADCC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Result and done flag
  // ----------------------------------------

  // Result kept until the next completed conversion; low power clears it
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result         <= 10'h000;
      conv_done_flag <= 1'b0;
    end else if (low_power_in) begin
      result         <= 10'h000;
      conv_done_flag <= 1'b0;
    end else begin
      conv_done_flag <= next_done;
      if (store_now) begin
        result <= sar_code;
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------

  // Bus read data stands one cycle after the strobe
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= ADCC_RD_IDLE;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // Analog controls and completion pulse
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      channel_select_out    <= 4'h0;
      analog_input_gate_out <= 1'b0;
      ladder_connect_out    <= 1'b0;
      sample_hold_out       <= 1'b0;
      conv_done_irq_out     <= 1'b0;
    end else begin
      channel_select_out    <= channel_select;
      analog_input_gate_out <= analog_input_gate;
      ladder_connect_out    <= next_ladder;
      sample_hold_out       <= (next_state == ADCC_ST_SAMPLE);
      conv_done_irq_out     <= store_now;
    end
  end

  // Trial code leaves straight from the SAR register; an extra stage would
  // leave the synchronised comparator answer stale at the shortest step length
  assign dac_code_out = sar_code;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------

  // Paces thirteen steps of step_len clocks each
  adcc_step_timer u_timer (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .start_in     (start_conv),
    .run_in       (timer_run),
    .step_len_in  (step_len),
    .step_out     (step_pulse),
    .last_out     (last_pulse),
    .step_idx_out (step_idx)
  );

  // Bit decisions use the synchronised comparator
  adcc_sar u_sar (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .clear_in    (start_conv),
    .decide_in   (sar_decide),
    .bit_pos_in  (bit_pos),
    .cmp_high_in (cmp_sync),
    .code_out    (sar_code)
  );

endmodule

`default_nettype wire

// ---- adcc_control_assertions.sv ----
// Port checker for the converter control block
`default_nettype none

module adcc_control_assertions
  import adcc_pkg::*;
(
  // Watched ports
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        low_power_in,
  input wire logic [3:0]  channel_select_out,
  input wire logic        analog_input_gate_out,
  input wire logic        ladder_connect_out,
  input wire logic        sample_hold_out,
  input wire logic [9:0]  dac_code_out,
  input wire logic        conv_done_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------
  // Completion, read-back and sampling
  // ----------------------------------------
  chk_irq_one_cycle: assert property (
    conv_done_irq_out |=> !conv_done_irq_out) else $error("irq pulse too long");
  chk_status_low_bits: assert property (
    reg_rd_in && reg_addr_in == ADCC_OFS_STATUS |=> reg_rdata_out[3:0] == 4'h0)
    else $error("status low bits not zero");
  chk_timing_top_bits: assert property (
    reg_rd_in && reg_addr_in == ADCC_OFS_TIMING |=> reg_rdata_out[7:6] == 2'h0)
    else $error("timing top bits not zero");
  chk_busy_sampling: assert property (
    reg_rd_in && reg_addr_in == ADCC_OFS_STATUS && sample_hold_out && !low_power_in |=> reg_rdata_out[4])
    else $error("busy low while sampling");
  chk_sar_start: assert property (
    $rose(sample_hold_out) |-> dac_code_out == ADCC_SAR_FIRST) else $error("trial code not reset at start");
  chk_sample_ladder: assert property (
    sample_hold_out ##1 sample_hold_out |-> ladder_connect_out) else $error("ladder open during conversion");

  // ----------------------------------------
  // Standby
  // ----------------------------------------
  chk_lp_ladder_off: assert property (
    low_power_in [*3] |-> !ladder_connect_out) else $error("ladder on in standby");
  chk_lp_no_irq: assert property (
    low_power_in ##1 low_power_in |-> !conv_done_irq_out) else $error("irq in standby");
  chk_lp_fields_clear: assert property (
    low_power_in [*3] |-> channel_select_out == 4'h0 && !analog_input_gate_out && !sample_hold_out)
    else $error("fields kept in standby");
  chk_lp_status_idle: assert property (
    low_power_in && $past(low_power_in) && reg_rd_in && reg_addr_in == ADCC_OFS_STATUS
    |=> reg_rdata_out == 8'h00) else $error("status not idle in standby");
endmodule

bind adcc_control adcc_control_assertions i_adcc_control_assertions (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .low_power_in(low_power_in), .channel_select_out(channel_select_out),
  .analog_input_gate_out(analog_input_gate_out), .ladder_connect_out(ladder_connect_out),
  .sample_hold_out(sample_hold_out), .dac_code_out(dac_code_out), .conv_done_irq_out(conv_done_irq_out)
);

`default_nettype wire

// ---- adcc_control_test.sv ----
// Self-checking bench for the converter control block
`default_nettype none

module adcc_control_test
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk_in   = 1'b0;
  logic        rst_in       = 1'b1;
  logic [15:0] reg_addr_in  = 16'h0000;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic        low_power_in = 1'b0;
  logic [7:0]  reg_rdata_out;
  logic        cmp_high_in;
  logic [3:0]  channel_select_out;
  logic        analog_input_gate_out;
  logic        ladder_connect_out;
  logic        sample_hold_out;
  logic [9:0]  dac_code_out;
  logic        conv_done_irq_out;
  logic [9:0]  last = 10'h000;
  int          errors = 0;
  int          cmp_count = 0;
  int          n;

  adcc_control i_adcc_control (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .low_power_in(low_power_in), .cmp_high_in(cmp_high_in), .channel_select_out(channel_select_out),
    .analog_input_gate_out(analog_input_gate_out), .ladder_connect_out(ladder_connect_out),
    .sample_hold_out(sample_hold_out), .dac_code_out(dac_code_out), .conv_done_irq_out(conv_done_irq_out));

  adcc_analog_model i_adcc_analog_model (.ref_clk_in(ref_clk_in), .channel_select_in(channel_select_out),
    .analog_input_gate_in(analog_input_gate_out), .sample_hold_in(sample_hold_out),
    .dac_code_in(dac_code_out), .cmp_high_out(cmp_high_in));

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 check(16'(reg_rdata_out), 16'(e));
  endtask

  // Bounded wait for the next completion pulse
  task automatic wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1 n++;
      if (n > lim) begin
        errors++;
        conclude();
      end
    end while (conv_done_irq_out !== 1'b1);
  endtask

  task automatic no_irq(input int cyc);
    repeat (cyc) begin
      @(posedge ref_clk_in);
      #1 check(16'(conv_done_irq_out), 16'h0);
    end
  endtask

  // Result read in the documented order, status first
  task automatic conv_check(input int c, input logic busy);
    logic [9:0] v;
    v = 10'(c * 61 + 17);
    rdc(ADCC_OFS_STATUS, {v[1:0], 1'b1, busy, 4'h0});
    rdc(ADCC_OFS_UPPER, v[9:2]);
    rdc(ADCC_OFS_STATUS, {v[1:0], 1'b0, busy, 4'h0});
    last = v;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(16'(dac_code_out), 16'h0200);
    wr(16'h0020, 8'hFF);
    wr(ADCC_OFS_STATUS, 8'hFF);
    rdc(ADCC_OFS_CTRL_A, 8'h00);
    rdc(ADCC_OFS_STATUS, 8'h00);
    rdc(ADCC_OFS_UPPER, 8'h00);
    rdc(16'h0020, 8'h00);
    wr(ADCC_OFS_TIMING, 8'hF8);
    rdc(ADCC_OFS_TIMING, 8'h38);
  endtask

  task automatic t_single();
    wr(ADCC_OFS_TIMING, 8'h10);
    for (int c = 0; c < 16; c++) begin
      wr(ADCC_OFS_CTRL_A, 8'h20 | 8'(c));
      wr(ADCC_OFS_CTRL_A, 8'hA0 | 8'(c));
      check(16'(channel_select_out), 16'(c));
      rdc(ADCC_OFS_STATUS, {last[1:0], 6'h10});
      rdc(ADCC_OFS_CTRL_A, 8'h20 | 8'(c));
      wait_irq(60);
      conv_check(c, 1'b0);
    end
  endtask

  task automatic t_times();
    int cd;
    int p;
    for (int k = 0; k < 6; k++) begin
      cd = (k == 0) ? 0 : k + 1;
      p = 39 << k;
      wr(ADCC_OFS_TIMING, 8'h10 | 8'(cd << 1));
      wr(ADCC_OFS_CTRL_A, 8'hA3);
      wait_irq(p + 8);
      check(16'(n >= p - 1 && n <= p + 6), 16'h1);
      conv_check(3, 1'b0);
    end
    check(16'(ladder_connect_out), 16'h0);
    wr(ADCC_OFS_TIMING, 8'h30);
    repeat (3) @(posedge ref_clk_in);
    #1 check(16'(ladder_connect_out), 16'h1);
  endtask

  task automatic t_repeat();
    wr(ADCC_OFS_TIMING, 8'h10);
    wr(ADCC_OFS_CTRL_A, 8'hE5);
    wait_irq(60);
    conv_check(5, 1'b1);
    wait_irq(45);
    conv_check(5, 1'b1);
    repeat (10) @(posedge ref_clk_in);
    wr(ADCC_OFS_CTRL_A, 8'h05);
    no_irq(80);
    rdc(ADCC_OFS_STATUS, {last[1:0], 6'h00});
    for (int m = 0; m < 3; m += 2) begin
      wr(ADCC_OFS_CTRL_A, 8'h85 | 8'(m << 5));
      no_irq(60);
      rdc(ADCC_OFS_STATUS, {last[1:0], 6'h00});
    end
    wr(ADCC_OFS_CTRL_A, 8'h30);
    repeat (2) @(posedge ref_clk_in);
    #1 check(16'(analog_input_gate_out), 16'h1);
    rdc(ADCC_OFS_CTRL_A, 8'h30);
  endtask

  task automatic t_lowpower();
    wr(ADCC_OFS_TIMING, 8'h1C);
    wr(ADCC_OFS_CTRL_A, 8'hA7);
    repeat (50) @(posedge ref_clk_in);
    low_power_in <= 1'b1;
    wr(ADCC_OFS_CTRL_A, 8'h3F);
    wr(ADCC_OFS_TIMING, 8'h3C);
    rdc(ADCC_OFS_CTRL_A, 8'h00);
    rdc(ADCC_OFS_TIMING, 8'h00);
    rdc(ADCC_OFS_STATUS, 8'h00);
    @(posedge ref_clk_in);
    low_power_in <= 1'b0;
    no_irq(40);
    rdc(ADCC_OFS_CTRL_A, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_single();
    t_times();
    t_repeat();
    t_lowpower();
    conclude();
  end
endmodule

`default_nettype wire

// ---- adcc_pkg.sv ----
// Shared constants for the converter control block
`default_nettype none

package adcc_pkg;

  // ----------------------------------------
  // Register offsets on the plain bus
  // ----------------------------------------
  localparam logic [15:0] ADCC_OFS_CTRL_A  = 16'h001C;
  localparam logic [15:0] ADCC_OFS_TIMING  = 16'h001D;
  localparam logic [15:0] ADCC_OFS_STATUS  = 16'h001E;
  localparam logic [15:0] ADCC_OFS_UPPER   = 16'h001F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ADCC_CA_TRIG_BIT   = 7;
  localparam int ADCC_CA_MODE_HI    = 6;
  localparam int ADCC_CA_MODE_LO    = 5;
  localparam int ADCC_CA_GATE_BIT   = 4;
  localparam int ADCC_CA_CHAN_HI    = 3;
  localparam int ADCC_TC_LADDER_BIT = 5;
  localparam int ADCC_TC_TIME_HI    = 3;
  localparam int ADCC_TC_TIME_LO    = 1;
  localparam int ADCC_TC_STORE_HI   = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ADCC_CTRL_A_RST = 8'h00;
  localparam logic [5:0] ADCC_TIMING_RST = 6'h00;
  localparam logic [7:0] ADCC_RD_IDLE    = 8'h00;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  localparam logic [1:0] ADCC_MODE_OFF    = 2'h0;
  localparam logic [1:0] ADCC_MODE_SINGLE = 2'h1;
  localparam logic [1:0] ADCC_MODE_REPEAT = 2'h3;

  // ----------------------------------------
  // Conversion time, in clock periods
  // ----------------------------------------
  localparam int ADCC_TIME_0_PERIODS = 39;
  localparam int ADCC_TIME_2_PERIODS = 78;
  localparam int ADCC_TIME_3_PERIODS = 156;
  localparam int ADCC_TIME_4_PERIODS = 312;
  localparam int ADCC_TIME_5_PERIODS = 624;
  localparam int ADCC_TIME_6_PERIODS = 1248;

  // Three sample steps then ten bit steps
  localparam int          ADCC_CONV_STEPS   = 13;
  localparam logic [3:0]  ADCC_SAMPLE_LAST  = 4'h2;
  localparam logic [3:0]  ADCC_STEP_LAST    = 4'hC;
  localparam logic [9:0]  ADCC_SAR_FIRST    = 10'h200;

  // Step length per time code; reserved codes fall back to neighbours
  function automatic logic [6:0] adcc_step_len(input logic [2:0] code);
    logic [6:0] len;
    len = 7'(ADCC_TIME_0_PERIODS / ADCC_CONV_STEPS);
    case (code)
      3'h2: len = 7'(ADCC_TIME_2_PERIODS / ADCC_CONV_STEPS);
      3'h3: len = 7'(ADCC_TIME_3_PERIODS / ADCC_CONV_STEPS);
      3'h4: len = 7'(ADCC_TIME_4_PERIODS / ADCC_CONV_STEPS);
      3'h5: len = 7'(ADCC_TIME_5_PERIODS / ADCC_CONV_STEPS);
      3'h6: len = 7'(ADCC_TIME_6_PERIODS / ADCC_CONV_STEPS);
      3'h7: len = 7'(ADCC_TIME_6_PERIODS / ADCC_CONV_STEPS);
      default: len = 7'(ADCC_TIME_0_PERIODS / ADCC_CONV_STEPS);
    endcase
    return len;
  endfunction

  // Conversion sequencer states, Gray along the single-conversion path
  typedef enum logic [1:0] {
    ADCC_ST_IDLE    = 2'h0,
    ADCC_ST_SAMPLE  = 2'h1,
    ADCC_ST_CONVERT = 2'h3,
    ADCC_ST_STORE   = 2'h2
  } adcc_state_e;

endpackage

`default_nettype wire

// ---- adcc_sar.sv ----
// Successive approximation register driving the ladder code
`default_nettype none

module adcc_sar
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic       decide_in,
  input  wire logic [3:0] bit_pos_in,
  input  wire logic       cmp_high_in,
  // Trial code
  output logic [9:0]      code_out
);

  logic [9:0] next_code;

  // Keep or drop the trial bit, then try the next lower one
  always_comb begin
    next_code = code_out;
    if (clear_in) begin
      next_code = ADCC_SAR_FIRST;
    end else if (decide_in) begin
      next_code[bit_pos_in] = cmp_high_in;
      if (bit_pos_in != 4'h0) begin
        next_code[bit_pos_in - 4'h1] = 1'b1;
      end
    end
  end

  // Code register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_out <= ADCC_SAR_FIRST;
    end else begin
      code_out <= next_code;
    end
  end

endmodule

`default_nettype wire

// ---- adcc_step_timer.sv ----
// Step timer pacing the sample and bit-decision steps
`default_nettype none

module adcc_step_timer
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       start_in,
  input  wire logic       run_in,
  input  wire logic [6:0] step_len_in,
  // Step events
  output logic            step_out,
  output logic            last_out,
  output logic [3:0]      step_idx_out
);

  logic [6:0] cyc;
  logic [3:0] idx;

  // ----------------------------------------
  // Step end decode
  // ----------------------------------------
  wire logic step_end = run_in && !start_in && (cyc == step_len_in - 7'h01);
  wire logic seq_end  = step_end && (idx == ADCC_STEP_LAST);

  // Cycle and step counters, restarted by start
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc <= 7'h00;
      idx <= 4'h0;
    end else if (start_in || !run_in || step_end) begin
      cyc <= 7'h00;
      idx <= (start_in || !run_in || seq_end) ? 4'h0 : idx + 4'h1;
    end else begin
      cyc <= cyc + 7'h01;
    end
  end

  // One-cycle events naming the step that just ended
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_out     <= 1'b0;
      last_out     <= 1'b0;
      step_idx_out <= 4'h0;
    end else begin
      step_out     <= step_end;
      last_out     <= seq_end;
      step_idx_out <= idx;
    end
  end

endmodule

`default_nettype wire
